// *** aqb_filter.sv ***
// Contract
// R1 - event-dataset magnitude attribute is always zero.
// R2 - event-dataset quality equals the published sampled-values channel quality.
// R3 - event-dataset time holds time of last published quality change.
// R4 - magnitude never published on event messaging; only quality and time meaningful.
// R5 - count quality change events per channel within each one-second interval.
// R6 - six events within a second with non-good latest quality enter burst.
// R7 - burst holds published quality; release after one full quiet second.
// R8 - burst entry emits an event naming channel and board; simultaneous entries get one event naming only the lowest channel.
// R9 - validity: questionable on range/inaccurate, invalid on failure/overflow, else good.
// R10 - overflow, bad-reference, oscillatory, old-data, inconsistent always false.
// R11 - failure set for internal errors other than synchronisation problems.
// R12 - inaccurate set when sample misses declared accuracy class.
// R13 - sampled-values source always process.
// R14 - no timestamp update during hold; on release publish, stamp if differs.
// R15 - event validity good/substituted/questionable/invalid, source process, test passed.

module aqb_filter
    import aqb_pkg::*;
#(
    parameter int                 N       = N_CHAN,
    parameter int                 SEC_CYCLES = SEC_CYC,
    parameter logic [BOARD_W-1:0] BOARD_ID = 4'h0
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // acquisition side
    input  wire aqb_flags_t [N-1:0]      flags,
    input  wire logic [TIME_W-1:0]       time_now,
    // sampled values side
    output aqb_qual_t [N-1:0]            sv_q,
    // event messaging side
    output aqb_ev_obj_t [N-1:0]          ev_obj,
    // burst reporting
    output logic [N-1:0]                 in_burst,
    output logic                         burst_evt,
    output aqb_burst_id_t                burst_id
);

    // ****************************************
    // one-second time base
    // ****************************************
    localparam int QW = $clog2(SEC_CYCLES + 1);
    localparam logic [QW-1:0] SEC_LAST  = QW'(SEC_CYCLES - 1);
    localparam logic [CNT_W-1:0] BURST_N = CNT_W'(BURST_EVENTS);

    logic [QW-1:0] sec_cnt_q;
    logic          sec_tick;

    assign sec_tick = (sec_cnt_q == SEC_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sec_cnt_q <= '0;
        end else if (ce) begin
            if (sec_tick) begin
                sec_cnt_q <= '0;
            end else begin
                sec_cnt_q <= sec_cnt_q + QW'(1);
            end
        end
    end

    // ****************************************
    // quality derivation
    // ****************************************
    function automatic aqb_qual_t derive_q(input aqb_flags_t f);
        aqb_qual_t r;
        r              = '0;
        r.overflow     = 1'b0; // R10
        r.bad_ref      = 1'b0; // R10
        r.oscillatory  = 1'b0; // R10
        r.old_data     = 1'b0; // R10
        r.inconsistent = 1'b0; // R10
        r.out_of_range = f.out_of_range;
        r.failure      = f.int_err & ~f.sync_err; // R11
        r.inaccurate   = f.acc_fail; // R12
        r.source       = SRC_PROCESS; // R13
        r.test         = f.test;
        r.op_blocked   = 1'b0;
        // invalid outranks questionable when both apply
        if (r.failure || r.overflow) begin
            r.validity = SV_INVALID; // R9
        end else if (r.out_of_range || r.inaccurate) begin
            r.validity = SV_QUESTIONABLE; // R9
        end else begin
            r.validity = SV_GOOD; // R9
        end
        return r;
    endfunction

    function automatic aqb_qual_t event_q(input aqb_qual_t q, input logic subst);
        aqb_qual_t r;
        r        = q; // R2
        r.source = SRC_PROCESS; // R15
        if (q.validity == SV_INVALID) begin
            r.validity = EV_INVALID; // R15
        end else if (q.validity == SV_QUESTIONABLE) begin
            r.validity = EV_QUESTIONABLE; // R15
        end else if (subst) begin
            r.validity = EV_SUBSTITUTED; // R15
        end else begin
            r.validity = EV_GOOD; // R15
        end
        return r;
    endfunction

    // ****************************************
    // per-channel burst filter
    // ****************************************
    logic [N-1:0] enter_burst;

    for (genvar c = 0; c < N; c++) begin : g_chan
        aqb_qual_t         raw_q;
        aqb_qual_t         last_q;
        aqb_qual_t         pub_q;
        logic [TIME_W-1:0] stamp_q;
        logic [CNT_W-1:0]  evt_cnt_q;
        logic [CNT_W-1:0]  evt_cnt_d;
        logic [QW-1:0]     quiet_q;
        aqb_state_t        state_q;
        logic              change;
        logic              release_hold;

        assign raw_q  = derive_q(flags[c]);
        assign change = (raw_q != last_q);

        // count restarts at each tick; an event on the tick counts for the new second
        always_comb begin
            evt_cnt_d = evt_cnt_q;
            if (sec_tick) begin
                evt_cnt_d = '0;
            end
            if (change && (evt_cnt_d != BURST_N)) begin
                evt_cnt_d = evt_cnt_d + CNT_W'(1); // R5
            end
        end

        assign enter_burst[c] = (state_q == AQB_NORMAL) && change &&
                                (evt_cnt_d == BURST_N) && (raw_q.validity != SV_GOOD); // R6
        assign release_hold   = (state_q == AQB_BURST) && !change && (quiet_q == SEC_LAST); // R7

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                last_q    <= '0;
                evt_cnt_q <= '0;
            end else if (ce) begin
                last_q    <= raw_q;
                evt_cnt_q <= evt_cnt_d; // R5
            end
        end

        // quiet time since the last change, saturating at one second
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                quiet_q <= '0;
            end else if (ce) begin
                if (change) begin
                    quiet_q <= '0;
                end else if (quiet_q != SEC_LAST) begin
                    quiet_q <= quiet_q + QW'(1);
                end
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                state_q <= AQB_NORMAL;
            end else if (ce) begin
                case (state_q)
                    AQB_NORMAL: begin
                        if (enter_burst[c]) begin
                            state_q <= AQB_BURST; // R6
                        end
                    end
                    AQB_BURST: begin
                        if (release_hold) begin
                            state_q <= AQB_NORMAL; // R7
                        end
                    end
                    default: begin
                        state_q <= AQB_NORMAL;
                    end
                endcase
            end
        end

        // the change that trips the burst is still published, then frozen
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                pub_q   <= '0;
                stamp_q <= '0;
            end else if (ce) begin
                if ((state_q == AQB_NORMAL) || release_hold) begin
                    pub_q <= raw_q; // R7
                    if (raw_q != pub_q) begin
                        stamp_q <= time_now; // R3 R14
                    end
                end
            end
        end

        always_ff @(posedge clk) begin
            if (!rst_n) begin
                sv_q[c]   <= '0;
                ev_obj[c] <= '0;
            end else if (ce) begin
                sv_q[c]       <= pub_q;
                ev_obj[c].mag <= MAG_EVENT; // R1 R4
                ev_obj[c].q   <= event_q(pub_q, flags[c].subst); // R2 R15
                ev_obj[c].t   <= stamp_q; // R3
            end
        end

        assign in_burst[c] = (state_q == AQB_BURST);
    end

    // ****************************************
    // burst event report
    // ****************************************
    // simultaneous entries report the lowest channel; others stay visible on in_burst
    logic [CHAN_W-1:0] first_chan;

    always_comb begin
        first_chan = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (enter_burst[i]) begin
                first_chan = CHAN_W'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            burst_evt <= 1'b0;
            burst_id  <= '0;
        end else if (ce) begin
            burst_evt <= |enter_burst; // R8
            if (|enter_burst) begin
                burst_id.board <= BOARD_ID; // R8
                burst_id.chan  <= first_chan; // R8
            end
        end
    end

endmodule // aqb_filter

// *** aqb_pkg.sv ***
package aqb_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ       = 100_000_000;
    localparam int SEC_S        = 1;
    localparam int SEC_CYC      = SEC_S * CLK_HZ;
    localparam int BURST_EVENTS = 6;
    localparam int CNT_W        = 3;
    localparam int TIME_W       = 64;
    localparam int MAG_W        = 32;
    localparam int N_CHAN       = 8;
    localparam int BOARD_W      = 4;
    localparam int CHAN_W       = 3;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] SV_GOOD         = 2'h0;
    localparam logic [1:0] SV_INVALID      = 2'h1;
    localparam logic [1:0] SV_QUESTIONABLE = 2'h3;
    localparam logic [1:0] EV_GOOD         = 2'h0;
    localparam logic [1:0] EV_INVALID      = 2'h1;
    localparam logic [1:0] EV_SUBSTITUTED  = 2'h2;
    localparam logic [1:0] EV_QUESTIONABLE = 2'h3;
    localparam logic       SRC_PROCESS     = 1'h0;
    localparam logic [MAG_W-1:0] MAG_EVENT = 32'h0000_0000;

    typedef enum logic [0:0] {
        AQB_NORMAL = 1'b0,
        AQB_BURST  = 1'b1
    } aqb_state_t;

    // per-channel conditions from acquisition, same clock domain
    typedef struct packed {
        logic out_of_range;
        logic acc_fail;
        logic int_err;
        logic sync_err;
        logic test;
        logic subst;
    } aqb_flags_t;

    typedef struct packed {
        logic [1:0] validity;
        logic       overflow;
        logic       out_of_range;
        logic       bad_ref;
        logic       oscillatory;
        logic       failure;
        logic       old_data;
        logic       inconsistent;
        logic       inaccurate;
        logic       source;
        logic       test;
        logic       op_blocked;
    } aqb_qual_t;

    typedef struct packed {
        logic [MAG_W-1:0]  mag;
        aqb_qual_t         q;
        logic [TIME_W-1:0] t;
    } aqb_ev_obj_t;

    typedef struct packed {
        logic [BOARD_W-1:0] board;
        logic [CHAN_W-1:0]  chan;
    } aqb_burst_id_t;

endpackage : aqb_pkg

// *** aqb_subscriber.sv ***
module aqb_subscriber
    import aqb_pkg::*;
#(
    parameter int N = 2
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // event messaging
    input  wire aqb_ev_obj_t [N-1:0] ev_obj,
    output int                       msg_count
);
    aqb_ev_obj_t [N-1:0] seen_q;
    // any change among the data objects in one cycle is one message on the wire
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_q <= '0;
            msg_count <= 0;
        end else begin
            seen_q <= ev_obj;
            if (ev_obj !== seen_q) msg_count <= msg_count + 1;
        end
    end
endmodule // aqb_subscriber

// *** aqb_filter_assertions.sv ***
module aqb_filter_assertions
    import aqb_pkg::*;
#(
    parameter int                 N          = N_CHAN,
    parameter int                 SEC_CYCLES = SEC_CYC,
    parameter logic [BOARD_W-1:0] BOARD_ID   = 4'h0
) (
    // clock and reset
    input wire logic                clk,
    input wire logic                rst_n,
    input wire logic                ce,
    // acquisition
    input wire aqb_flags_t [N-1:0]  flags,
    input wire logic [TIME_W-1:0]   time_now,
    // published
    input wire aqb_qual_t [N-1:0]   sv_q,
    input wire aqb_ev_obj_t [N-1:0] ev_obj,
    input wire logic [N-1:0]        in_burst,
    input wire logic                burst_evt,
    input wire aqb_burst_id_t       burst_id
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // burst state at the last enabled edge; a pulse frozen by ce is not a second entry
    logic [N-1:0] in_burst_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_burst_q <= '0;
        end else if (ce) begin
            in_burst_q <= in_burst;
        end
    end
    a_board_id: assert property (burst_evt |-> burst_id.board == BOARD_ID) else $error("bad board id");
    a_evt_entry: assert property (burst_evt |-> in_burst[burst_id.chan] && !in_burst_q[burst_id.chan])
        else $error("burst pulse without entry");
    for (genvar i = 0; i < N; i++) begin : g_ch
        a_mag_zero: assert property (ev_obj[i].mag == MAG_EVENT) else $error("magnitude not zero");
        a_fixed_bits: assert property ({sv_q[i].overflow, sv_q[i].bad_ref, sv_q[i].oscillatory,
            sv_q[i].old_data, sv_q[i].inconsistent, sv_q[i].source} == 6'h00) else $error("fixed bit set");
        a_ev_same: assert property ({ev_obj[i].q.out_of_range, ev_obj[i].q.failure, ev_obj[i].q.inaccurate,
            ev_obj[i].q.test} == {sv_q[i].out_of_range, sv_q[i].failure, sv_q[i].inaccurate, sv_q[i].test})
            else $error("event quality differs");
        a_valid_inv: assert property (sv_q[i].failure |-> sv_q[i].validity == SV_INVALID)
            else $error("failure not invalid");
        a_valid_quest: assert property (!sv_q[i].failure && (sv_q[i].out_of_range || sv_q[i].inaccurate)
            |-> sv_q[i].validity == SV_QUESTIONABLE) else $error("not questionable");
        // two cycles in: the change that trips the burst is still landing
        a_hold_burst: assert property (in_burst[i] && $past(in_burst[i], 2) |->
            $stable(sv_q[i]) && $stable(ev_obj[i].t)) else $error("quality moved in hold");
    end
    c_entry: cover property (burst_evt);
    c_release: cover property ($fell(in_burst[0]));
    c_quest: cover property (sv_q[N-1].validity == SV_QUESTIONABLE);
endmodule // aqb_filter_assertions

bind aqb_filter aqb_filter_assertions #(.N(N), .SEC_CYCLES(SEC_CYCLES), .BOARD_ID(BOARD_ID))
    aqb_filter_assertions_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .flags(flags), .time_now(time_now),
    .sv_q(sv_q), .ev_obj(ev_obj), .in_burst(in_burst), .burst_evt(burst_evt), .burst_id(burst_id));

// *** aqb_filter_tb_top.sv ***
module aqb_filter_tb_top
    import aqb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 2;
    localparam int SEC = 40;
    localparam logic [BOARD_W-1:0] BID = 4'h5;
    logic               clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               ce = 1'b1;
    aqb_flags_t [N-1:0] flags = '0;
    logic [TIME_W-1:0]  time_now = '0;
    aqb_qual_t [N-1:0]  sv_q;
    aqb_ev_obj_t [N-1:0] ev_obj;
    logic [N-1:0]       in_burst;
    logic               burst_evt;
    aqb_burst_id_t      burst_id;
    int                 msg_count;
    int                 n_mismatch = 0;
    int                 check_count = 0;
    always #5 clk = ~clk;
    always @(posedge clk) time_now <= time_now + 64'h1;
    aqb_filter #(.N(N), .SEC_CYCLES(SEC), .BOARD_ID(BID)) aqb_filter_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
        .flags(flags), .time_now(time_now), .sv_q(sv_q), .ev_obj(ev_obj), .in_burst(in_burst),
        .burst_evt(burst_evt), .burst_id(burst_id));
    aqb_subscriber #(.N(N)) aqb_subscriber_inst (.clk(clk), .rst_n(rst_n), .ev_obj(ev_obj), .msg_count(msg_count));
    // ****
    // expectation and compare
    // ****
    function automatic aqb_qual_t exp_q(aqb_flags_t f, bit ev);
        aqb_qual_t q;
        q = '0;
        q.out_of_range = f.out_of_range;
        q.inaccurate = f.acc_fail;
        q.failure = f.int_err & ~f.sync_err;
        q.test = f.test;
        if (q.failure) q.validity = SV_INVALID;
        else if (q.out_of_range | q.inaccurate) q.validity = SV_QUESTIONABLE;
        else if (ev & f.subst) q.validity = EV_SUBSTITUTED;
        return q;
    endfunction
    task automatic cmp_q(string what, aqb_qual_t e, aqb_qual_t g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_v(string what, logic [63:0] e, logic [63:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic put(int ch, aqb_flags_t f);
        @(posedge clk);
        flags[ch] <= f;
    endtask
    // ****
    // scenarios
    // ****
    task automatic test_burst();
        logic [TIME_W-1:0] t_held;
        int base;
        int k;
        // sixth change lands on good, seventh on invalid
        for (k = 0; k < 7; k++) put(0, (k % 2 == 0) ? 6'h08 : 6'h00);
        #1;
        cmp_v("in_burst_good6", 64'h0, 64'(in_burst[0]));
        @(posedge clk);
        #1;
        cmp_v("in_burst", 64'h1, 64'(in_burst[0]));
        cmp_v("burst_evt", 64'h1, 64'(burst_evt));
        cmp_v("burst_id", 64'({BID, 3'h0}), 64'(burst_id));
        @(posedge clk);
        #1;
        cmp_v("burst_evt_end", 64'h0, 64'(burst_evt));
        cmp_q("sv_q_trip", exp_q(6'h08, 1'b0), sv_q[0]);
        t_held = ev_obj[0].t;
        // the trip's own message reaches the subscriber one edge later
        @(posedge clk);
        #1;
        base = msg_count;
        for (k = 0; k < 4; k++) put(0, (k % 2 == 0) ? 6'h20 : 6'h00);
        repeat (3) @(posedge clk);
        #1;
        cmp_q("sv_q_held", exp_q(6'h08, 1'b0), sv_q[0]);
        cmp_v("t_held", t_held, ev_obj[0].t);
        cmp_v("msgs_held", 64'(base), 64'(msg_count));
        k = 0;
        while (in_burst[0] !== 1'b0 && k < 60) begin
            @(posedge clk);
            #1;
            k++;
        end
        cmp_v("quiet_span", 64'h1, 64'(k >= SEC - 4 && k <= SEC + 2));
        @(posedge clk);
        #1;
        cmp_q("sv_q_release", exp_q(6'h00, 1'b0), sv_q[0]);
        cmp_v("t_release", time_now - 64'h2, ev_obj[0].t);
        $display("test_burst done");
    endtask
    task automatic test_table();
        aqb_flags_t tbl [5];
        tbl = '{6'h20, 6'h1C, 6'h08, 6'h03, 6'h30};
        foreach (tbl[k]) begin
            put(1, tbl[k]);
            repeat (2) @(posedge clk);
            #1;
            cmp_q("sv_q", exp_q(tbl[k], 1'b0), sv_q[1]);
            cmp_q("ev_q", exp_q(tbl[k], 1'b1), ev_obj[1].q);
            cmp_v("ev_t", time_now - 64'h2, ev_obj[1].t);
            cmp_v("ev_mag", 64'h0, 64'(ev_obj[1].mag));
        end
        $display("test_table done");
    endtask
    task automatic test_freeze_reset();
        // ce low freezes the channel; the thawed change is a sixth event on good, so no burst
        @(posedge clk);
        ce <= 1'b0;
        flags[1] <= 6'h02;
        repeat (3) @(posedge clk);
        #1;
        cmp_q("sv_q_frozen", exp_q(6'h30, 1'b0), sv_q[1]);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        cmp_q("sv_q_thaw", exp_q(6'h02, 1'b0), sv_q[1]);
        cmp_v("in_burst_good", 64'h0, 64'(in_burst[1]));
        // mid-run reset clears published state
        @(posedge clk);
        rst_n <= 1'b0;
        flags <= '0;
        repeat (2) @(posedge clk);
        #1;
        cmp_q("sv_q_rst", '0, sv_q[1]);
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        cmp_v("t_rst", 64'h0, ev_obj[1].t);
        cmp_v("id_rst", 64'h0, 64'(burst_id));
        put(1, 6'h20);
        repeat (2) @(posedge clk);
        #1;
        cmp_q("sv_q_after", exp_q(6'h20, 1'b0), sv_q[1]);
        cmp_v("t_after", time_now - 64'h2, ev_obj[1].t);
        $display("test_freeze_reset done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        test_burst();
        test_table();
        test_freeze_reset();
        conclude();
    end
    // run needs about 95 cycles
    initial begin
        #50000;
        n_mismatch++;
        conclude();
    end
endmodule // aqb_filter_tb_top
